//--- rtl/sof_formatter.sv
// Sample output code formatter: convert timing, one-deep output pipeline,
// code inversion and the active-low conversion-done flag.
// Assumes convert strobe and selects are synchronous to core_clk; select
// pull-ups sit outside, so an open select arrives here as one.
`timescale 1ns/1ps
module sof_formatter (
  input  wire logic                       core_clk,            // Clock
  input  wire logic                       rst,                 // Sync reset
  input  wire logic                       clk_en,              // Freeze low
  input  wire logic                       convert,             // Convert strobe
  input  wire logic [sof_pkg::DATA_W-1:0] sample_in,           // Comparator
  input  wire logic                       msb_invert_sel,      // Top select
  input  wire logic                       low_bits_invert_sel, // Low select
  input  wire logic                       done_fast,           // Short delay
  output logic      [sof_pkg::DATA_W-1:0] data_out,            // Output word
  output logic                            conv_done_n          // Valid, low
);
  // Convert sequencer states
  typedef enum logic [1:0] {
    SOF_IDLE,      // Waiting for a convert rising edge
    SOF_CLK_HIGH,  // Internal converter clock held high
    SOF_DONE_WAIT  // Clock low, settling before the done flag
  } sof_state_type;

  sof_state_type                   state_q, state_d;   // Sequencer state
  logic [sof_pkg::CNT_W-1:0]       cnt_q, cnt_d;       // Timing counter
  logic                            conv_q, conv_d;     // Strobe history
  logic [sof_pkg::DATA_W-1:0]      pend_q, pend_d;     // Held N-1 result
  logic [sof_pkg::DATA_W-1:0]      out_q, out_d;       // Output latch
  logic                            done_n_q, done_n_d; // Done flag
  logic [sof_pkg::DATA_W-1:0]      coded;              // Formatted sample
  logic                            start;              // Strobe rising edge
  logic                            adc_clk;            // Internal clock
  logic                            take;               // Accepted start

  // Inversion of the comparator result
  sof_invert #(
    .WIDTH (sof_pkg::DATA_W)
  ) u_inv (
    .raw_word            (sample_in),
    .msb_invert_sel      (msb_invert_sel),
    .low_bits_invert_sel (low_bits_invert_sel),
    .coded_word          (coded)
  );

  // A rise is seen against the strobe level of the previous enabled cycle;
  // the history resets low, so a strobe already high at release counts.
  assign start   = convert & ~conv_q;
  // Only a rise met while idle is a conversion; rises while busy are lost
  assign take    = start && (state_q == SOF_IDLE);
  // The internal converter clock is high for the whole clock-high state
  assign adc_clk = (state_q == SOF_CLK_HIGH);

  // Timing of one accepted conversion, counted from the start edge c0:
  //   c1     output word takes the held result of the previous conversion,
  //          the new formatted sample is held, and the done flag rises
  //   c1-c4  internal converter clock high (high time rounded up)
  //   c5-c6  clock low, output settling before it is flagged
  //   c7     done flag falls and stays low until the next accepted start
  // Both done delays round up to the same count at this clock rate, so
  // the short option only shows at finer clock periods.
  // The word formatted at a start waits for the following start before it
  // reaches the output: the pipeline is one conversion deep, and the
  // first conversion after reset shows the all-zero reset word.
  // Hazard: the selects are read at the start edge only; moving them
  // while a conversion is in flight changes nothing until the next start.

  // Next-state logic for the convert sequencer
  // Defaults hold every register; the strobe history always follows.
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    conv_d   = convert;
    pend_d   = pend_q;
    out_d    = out_q;
    done_n_d = done_n_q;
    unique case (state_q)
      SOF_IDLE: begin
        if (start) begin // Raise internal clock, release previous word
          state_d  = SOF_CLK_HIGH;
          cnt_d    = 4'(sof_pkg::CLK_HIGH_CYC);
          out_d    = pend_q;
          pend_d   = coded;
          done_n_d = 1'b1;
        end
      end
      // Count down the internal clock high time
      SOF_CLK_HIGH: begin
        if (cnt_q == sof_pkg::CNT_ONE) begin // Clock falls
          state_d = SOF_DONE_WAIT;
          cnt_d   = done_fast ? 4'(sof_pkg::DONE_FAST_CYC)
                              : 4'(sof_pkg::DONE_DLY_CYC);
        end else begin // Clock still high
          cnt_d = cnt_q - sof_pkg::CNT_ONE;
        end
      end
      // Count down the settling delay before flagging the word
      SOF_DONE_WAIT: begin
        if (cnt_q == sof_pkg::CNT_ONE) begin // Flag the word valid
          state_d  = SOF_IDLE;
          cnt_d    = sof_pkg::CNT_ZERO;
          done_n_d = 1'b0;
        end else begin
          cnt_d = cnt_q - sof_pkg::CNT_ONE;
        end
      end
    endcase
  end

  // State registers; clock enable low freezes everything in place
  always_ff @(posedge core_clk) begin
    if (rst) begin // Idle, empty pipeline, nothing flagged
      state_q  <= SOF_IDLE;
      cnt_q    <= sof_pkg::CNT_ZERO;
      conv_q   <= 1'b0;
      pend_q   <= sof_pkg::WORD_ZERO;
      out_q    <= sof_pkg::WORD_ZERO;
      done_n_q <= 1'b1;
    end else if (clk_en) begin // Advance one enabled cycle
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      conv_q   <= conv_d;
      pend_q   <= pend_d;
      out_q    <= out_d;
      done_n_q <= done_n_d;
    end
  end

  // Outputs straight from flip-flops
  assign data_out    = out_q;
  assign conv_done_n = done_n_q;

  // Checks
  // All checks run on the core clock and sleep through reset and freeze;
  // an attempt caught by either is dropped, not failed.
  // The code checks look one cycle after an accepted start, when the
  // formatted sample has just been held, and compare it against the
  // sample as it stood at the start edge.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  AST_NO_INV: assert property (
    (take && msb_invert_sel && low_bits_invert_sel)
      |-> ##1 pend_q == $past(sample_in))
    else $error("straight code altered");
  AST_MSB_ONLY: assert property (
    (take && !msb_invert_sel && low_bits_invert_sel)
      |-> ##1 pend_q == ($past(sample_in) ^ 8'h80))
    else $error("msb-only inversion wrong");
  AST_LOW_ONLY: assert property (
    (take && msb_invert_sel && !low_bits_invert_sel)
      |-> ##1 pend_q == ($past(sample_in) ^ 8'h7f))
    else $error("low-bit inversion wrong");
  AST_BOTH: assert property (
    (take && !msb_invert_sel && !low_bits_invert_sel)
      |-> ##1 pend_q == ~$past(sample_in))
    else $error("full inversion wrong");
  AST_CLK_RISE: assert property (
    (start && state_q == SOF_IDLE) |-> ##1 adc_clk [*4] ##1 !adc_clk)
    else $error("internal clock width wrong");
  AST_PIPE: assert property (
    (start && state_q == SOF_IDLE) |-> ##1 data_out == $past(pend_q))
    else $error("output not one conversion late");
  AST_DONE_SLOW: assert property (
    ($fell(adc_clk) && !$past(done_fast))
      |-> conv_done_n [*1] ##1 conv_done_n ##1 !conv_done_n)
    else $error("done delay wrong");
  AST_DONE_FAST: assert property (
    ($fell(adc_clk) && $past(done_fast))
      |-> conv_done_n ##1 conv_done_n ##1 !conv_done_n)
    else $error("fast done delay wrong");
  AST_DONE_HIGH: assert property (
    adc_clk |-> conv_done_n)
    else $error("done low while clock high");
  // A rise while busy must leave the held result alone
  AST_BUSY_IGNORED: assert property (
    (start && state_q != SOF_IDLE) |=> pend_q == $past(pend_q))
    else $error("start taken while busy");
  // The output word only moves at an accepted start
  AST_WORD_HOLDS: assert property (
    !take |=> data_out == $past(data_out))
    else $error("output word moved without a start");
  // Once low, the done flag stands until the next accepted start
  AST_DONE_STANDS: assert property (
    (!conv_done_n && !take) |=> !conv_done_n)
    else $error("done flag dropped early");

  // Main scenarios worth seeing at least once

  COV_START: cover property (start && state_q == SOF_IDLE);
  COV_DONE: cover property ($fell(conv_done_n));
  COV_FAST: cover property ($fell(adc_clk) && done_fast);
  COV_INV: cover property (start && !msb_invert_sel);
  COV_BUSY: cover property (start && state_q != SOF_IDLE);
endmodule

//--- rtl/sof_pkg.sv
// Package for the sample output code formatter.
// Assumes a single 100 MHz core clock; both design files refer to it by
// scope, so nothing is imported.
package sof_pkg;
  localparam int DATA_W          = 8;       // Output word width
  localparam int MSB_POS         = 7;       // Position of data bit one
  localparam int CLK_PERIOD_NS   = 10;      // Core clock period
  localparam int CLK_HIGH_NS     = 37;      // Internal converter clock high
  localparam int DONE_DLY_NS     = 20;      // Done flag delay, normal
  localparam int DONE_DLY_FAST_NS = 16;     // Done flag delay, short option
  // Least times round up to whole cycles
  localparam int CLK_HIGH_CYC  = (CLK_HIGH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int DONE_DLY_CYC  = (DONE_DLY_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int DONE_FAST_CYC = (DONE_DLY_FAST_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W = 4;                 // Width of the timing counter
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 8'h00;
endpackage

//--- rtl/sof_invert.sv
// Combinational code inversion of one sample word.
// Assumes the selects are static while converting.
`timescale 1ns/1ps
module sof_invert #(
  parameter int WIDTH = sof_pkg::DATA_W
) (
  input  wire logic [WIDTH-1:0] raw_word,            // Straight binary sample
  input  wire logic             msb_invert_sel,      // Low inverts top bit
  input  wire logic             low_bits_invert_sel, // Low inverts others
  output logic      [WIDTH-1:0] coded_word           // Formatted word
);
  // Each bit XORed with the complement of its governing select
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      if (i == WIDTH - 1) begin : g_msb
        assign coded_word[i] = raw_word[i] ^ ~msb_invert_sel;
      end else begin : g_low
        assign coded_word[i] = raw_word[i] ^ ~low_bits_invert_sel;
      end
    end
  endgenerate
endmodule

//--- dv/sof_capture.sv
// Capture model: takes the output word as the done flag falls.
// Assumes done and data are registered on core_clk.
`timescale 1ns/1ps
module sof_capture (
  input  wire logic       core_clk,    // Clock
  input  wire logic [7:0] data_word,   // Formatted word
  input  wire logic       conv_done_n, // Valid, low
  output logic      [7:0] cap_word     // Captured word
);
  logic done_q; // Done level one cycle back
  // Latch on the first cycle that done reads low
  always_ff @(posedge core_clk) begin
    done_q <= conv_done_n;
    if (done_q && !conv_done_n) begin
      cap_word <= data_word;
    end
  end
endmodule

//--- dv/testbench.sv
// Testbench for the sample output code formatter.
// Assumes the capture model beside it and selects held per conversion.
`timescale 1ns/1ps
module testbench;
  logic       core_clk, rst, convert, msel, lsel, fast; // Inputs
  logic       clk_en;                                  // Freeze low
  logic [7:0] sample, data_out, cap_word;              // Words
  logic       conv_done_n;                             // Valid, low
  int         fails, n_checks;                         // Counters
  sof_formatter sof_formatter_inst (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .convert(convert), .sample_in(sample),
    .msb_invert_sel(msel), .low_bits_invert_sel(lsel), .done_fast(fast),
    .data_out(data_out), .conv_done_n(conv_done_n));
  sof_capture sof_capture_inst (.core_clk(core_clk), .data_word(data_out),
    .conv_done_n(conv_done_n), .cap_word(cap_word));
  // Free-running 100 MHz clock
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Compare one word or flag
  task automatic cmp(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  // One conversion; poke re-raises convert while busy
  task automatic conv(input logic [7:0] raw, input logic ms, ls, pk);
    int cyc;
    @(posedge core_clk); #1;
    sample = raw; msel = ms; lsel = ls; fast = ~fast; convert = 1;
    @(posedge core_clk); #1;
    convert = 0;
    cmp("done_at_start", 8'h01, {7'h0, conv_done_n});
    cyc = 1;
    while (conv_done_n !== 1'b0) begin
      if (cyc > 20) begin
        fails++;
        end_sim;
      end
      @(posedge core_clk); #1;
      cyc++;
      if (pk) convert = (cyc == 3);
    end
    cmp("start_to_done", 8'h07, cyc[7:0]);
    @(posedge core_clk); #1;
  endtask
  // Every select setting on the four table inputs
  task automatic t_codes;
    logic [7:0] prev, raw [4];
    logic       ms, ls;
    raw = '{8'h80, 8'h00, 8'hff, 8'h01};
    prev = 8'h00;
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 4; i++) begin
        ms = s[1];
        ls = s[0];
        conv(raw[i], ms, ls, 1'b0);
        cmp("captured", prev, cap_word);
        prev = raw[i] ^ {~ms, {7{~ls}}};
      end
    end
    conv(8'h00, 1'b1, 1'b1, 1'b0);
    cmp("last_word", prev, cap_word);
  endtask
  // A rise during busy is ignored and leaves the pipeline in step
  task automatic t_busy;
    conv(8'h3c, 1'b1, 1'b0, 1'b1);
    conv(8'h55, 1'b1, 1'b1, 1'b0);
    cmp("busy_word", 8'h43, cap_word);
  endtask
  // Clock enable low freezes a conversion in flight
  task automatic t_freeze;
    @(posedge core_clk); #1;
    sample = 8'h12; convert = 1;
    @(posedge core_clk); #1;
    convert = 0; clk_en = 0;
    repeat (10) @(posedge core_clk);
    #1;
    cmp("frozen_done", 8'h01, {7'h0, conv_done_n});
    cmp("frozen_word", 8'h55, data_out);
    clk_en = 1;
    repeat (8) @(posedge core_clk);
    #1;
    conv(8'h00, 1'b1, 1'b1, 1'b0);
    cmp("thawed_word", 8'h12, cap_word);
  endtask
  // Reset, then scenarios
  initial begin
    fails = 0;
    n_checks = 0;
    rst = 1; convert = 0; sample = 8'h00; msel = 1; lsel = 1; fast = 0;
    clk_en = 1;
    repeat (6) @(posedge core_clk);
    #1;
    cmp("rst_word", 8'h00, data_out);
    cmp("rst_done", 8'h01, {7'h0, conv_done_n});
    rst = 0;
    t_codes;
    t_busy;
    t_freeze;
    end_sim;
  end
endmodule
